/* gpio_pkg.sv */
// constants shared by the gpio port block and its assertion checker
package gpio_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] B_PIN_DATA_OFS = 8'h00;
    localparam logic [7:0] B_LATCH_OFS = 8'h04;
    localparam logic [7:0] B_DIR_OFS = 8'h08;
    localparam logic [7:0] B_ANALOG_OFS = 8'h0C;
    localparam logic [7:0] B_PULLUP_OFS = 8'h10;
    localparam logic [7:0] B_THRESH_OFS = 8'h14;
    localparam logic [7:0] C_PIN_DATA_OFS = 8'h20;
    localparam logic [7:0] C_LATCH_OFS = 8'h24;
    localparam logic [7:0] C_DIR_OFS = 8'h28;
    localparam logic [7:0] C_ANALOG_OFS = 8'h2C;
    localparam logic [7:0] C_PULLUP_OFS = 8'h30;
    localparam logic [7:0] C_THRESH_OFS = 8'h34;
    localparam logic [7:0] OPTION_OFS = 8'h40;
    localparam int ADDR_BITS = 8;
    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam int B_PINS = 4;
    localparam int B_LSB = 4;
    localparam int C_MAX_PINS = 8;
    localparam int GLOBAL_PU_DIS_BIT = 7;
    localparam logic [7:0] B_IMPL_MASK = 8'hF0;
    localparam logic [7:0] B_ANALOG_MASK = 8'h30;
    localparam logic [7:0] C_ANALOG_MASK = 8'hCF;
    localparam int NSRC = 5;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic [7:0] DIR_RST = 8'hFF;
    localparam logic [7:0] ANALOG_RST = 8'hFF;
    localparam logic [7:0] PULLUP_RST = 8'hFF;
    localparam logic [7:0] B_THRESH_RST = 8'h00;
    localparam logic [7:0] C_THRESH_RST = 8'hFF;
    localparam logic [7:0] OPTION_RST = 8'h80;
    // ------------------------------------------------------------
    // bus codes
    // ------------------------------------------------------------
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_BYTE = 3'h0;
    localparam logic [2:0] HSIZE_HALF = 3'h1;
endpackage

/* pin_select_if.sv */
// carrier between the port registers and the per-pin output selector
`timescale 1ns/1ps
interface pin_select_if #(
    parameter int W = 4,
    parameter int NS = 5
);
    logic [W*NS-1:0] src_en;
    logic [W*NS-1:0] src_drv;
    logic [W*NS-1:0] src_val;
    logic [W-1:0] lat;
    logic [W-1:0] dir;
    logic [W-1:0] pin_val;
    logic [W-1:0] pin_drv;
    modport regs (
        output src_en, src_drv, src_val, lat, dir,
        input pin_val, pin_drv
    );
    modport sel (
        input src_en, src_drv, src_val, lat, dir,
        output pin_val, pin_drv
    );
endinterface

/* pin_priority_select.sv */
// fixed-priority selector handing each pin to its first enabled source
`timescale 1ns/1ps
module pin_priority_select #(
    parameter int W = 4,
    parameter int NS = 5
) (
    pin_select_if.sel port
);
    // ------------------------------------------------------------
    // selection
    // ------------------------------------------------------------
    // index 0 is the highest priority; the port latch is the fallback
    always_comb begin
        port.pin_val = port.lat;
        port.pin_drv = ~port.dir;
        for (int p = 0; p < W; p++) begin
            for (int s = NS - 1; s >= 0; s--) begin
                if (port.src_en[p*NS+s]) begin
                    port.pin_val[p] = port.src_val[p*NS+s];
                    port.pin_drv[p] = port.src_drv[p*NS+s];
                end
            end
        end
    end
endmodule

/* gpio_port_block.sv */
// two-port general-purpose pin block with an AHB-Lite register slave
//
// Summary of operation
// - second port pins 7..4 pick schmitt (1) or ttl (0) input level.
// - unimplemented register bits ignore writes and read zero.
// - third port is six or eight pins wide, set by a parameter.
// - direction bit one makes the pin an input, driver off.
// - direction bit zero drives the pin from its output latch.
// - pin data reads return pin levels; writes go to the latch.
// - pin data writes merge written bytes with current pin levels.
// - direction bits control drivers even for analog pins.
// - analog pins read zero in digital port reads.
// - each third port pin has a weak pull-up with its own enable.
// - pull-up is off whenever the pin drives as an output.
// - after reset the global pull-up disable bit is set.
// - analog select zeroes reads and disables the input buffer.
// - analog select leaves digital output driving unchanged.
// - lowest-numbered enabled peripheral owns the pin.
// - input functions still see the pin while it is an output.
// - overriding input functions take part in the pin priority.
// - pull-up on only if global disable clear and pin enable set.
// - in the narrow variant third port bits 7 and 6 read zero.
//
// Added by the designer: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
module gpio_port_block #(
    parameter int C_PINS = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [gpio_pkg::B_PINS-1:0] b_st_in,
    input wire logic [gpio_pkg::B_PINS-1:0] b_ttl_in,
    output logic [gpio_pkg::B_PINS-1:0] b_out,
    output logic [gpio_pkg::B_PINS-1:0] b_oe_n,
    output logic [gpio_pkg::B_PINS-1:0] b_pullup_on,
    output logic [gpio_pkg::B_PINS-1:0] b_dig_in_en,
    output logic [gpio_pkg::B_PINS-1:0] b_level,
    output logic b_change,
    input wire logic [gpio_pkg::B_PINS*gpio_pkg::NSRC-1:0] b_src_en,
    input wire logic [gpio_pkg::B_PINS*gpio_pkg::NSRC-1:0] b_src_drv,
    input wire logic [gpio_pkg::B_PINS*gpio_pkg::NSRC-1:0] b_src_val,
    input wire logic [C_PINS-1:0] c_st_in,
    input wire logic [C_PINS-1:0] c_ttl_in,
    output logic [C_PINS-1:0] c_out,
    output logic [C_PINS-1:0] c_oe_n,
    output logic [C_PINS-1:0] c_pullup_on,
    output logic [C_PINS-1:0] c_dig_in_en,
    output logic [C_PINS-1:0] c_level,
    output logic c_change,
    input wire logic [C_PINS*gpio_pkg::NSRC-1:0] c_src_en,
    input wire logic [C_PINS*gpio_pkg::NSRC-1:0] c_src_drv,
    input wire logic [C_PINS*gpio_pkg::NSRC-1:0] c_src_val
);
    localparam int BP = gpio_pkg::B_PINS;
    localparam int BL = gpio_pkg::B_LSB;
    localparam int NS = gpio_pkg::NSRC;
    localparam int AW = gpio_pkg::ADDR_BITS;
    localparam logic [7:0] C_IMPL_MASK = 8'(( 9'h001 << C_PINS) - 9'h001);
    localparam logic [7:0] C_ANA_MASK = C_IMPL_MASK & gpio_pkg::C_ANALOG_MASK;

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    // byte lanes of the low byte touched by a transfer of this size
    function automatic logic lane0_hit(input logic [2:0] size,
                                       input logic [1:0] lo);
        lane0_hit = (size == gpio_pkg::HSIZE_BYTE) ? (lo == 2'h0) :
                    (size == gpio_pkg::HSIZE_HALF) ? (lo[1] == 1'b0) :
                    1'b1;
    endfunction

    // masked register update; only implemented bits ever change
    function automatic logic [7:0] masked_write(input logic [7:0] old,
                                                input logic [7:0] wr,
                                                input logic [7:0] impl);
        masked_write = (old & ~impl) | (wr & impl);
    endfunction

    // digital read value: threshold pick, then analog mask
    function automatic logic [7:0] digital_read(input logic [7:0] st,
                                                input logic [7:0] ttl,
                                                input logic [7:0] sel,
                                                input logic [7:0] ana,
                                                input logic [7:0] impl);
        digital_read = ((st & sel) | (ttl & ~sel)) & ~ana & impl;
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] b_latch_ff;
    logic [7:0] b_dir_ff;
    logic [7:0] b_analog_ff;
    logic [7:0] b_pullup_ff;
    logic [7:0] b_thresh_ff;
    logic [7:0] c_latch_ff;
    logic [7:0] c_dir_ff;
    logic [7:0] c_analog_ff;
    logic [7:0] c_pullup_ff;
    logic [7:0] c_thresh_ff;
    logic [7:0] option_ff;
    logic [31:0] hrdata_ff;
    logic wr_pend_ff;
    logic [AW-1:0] wr_addr_ff;
    logic lane0_ff;

    // ------------------------------------------------------------
    // pin input synchronisers
    // ------------------------------------------------------------
    // both threshold paths are synchronised so a threshold switch only
    // swaps between two settled levels; the switch itself can still
    // show as an edge, which software avoids while peripherals run
    logic [BP-1:0] b_st_s1_ff, b_st_s2_ff, b_st_s3_ff, b_st_ff;
    logic [BP-1:0] b_tt_s1_ff, b_tt_s2_ff, b_tt_s3_ff, b_tt_ff;
    logic [C_PINS-1:0] c_st_s1_ff, c_st_s2_ff, c_st_s3_ff, c_st_ff;
    logic [C_PINS-1:0] c_tt_s1_ff, c_tt_s2_ff, c_tt_s3_ff, c_tt_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            b_st_s1_ff <= '0;
            b_st_s2_ff <= '0;
            b_st_s3_ff <= '0;
            b_tt_s1_ff <= '0;
            b_tt_s2_ff <= '0;
            b_tt_s3_ff <= '0;
            c_st_s1_ff <= '0;
            c_st_s2_ff <= '0;
            c_st_s3_ff <= '0;
            c_tt_s1_ff <= '0;
            c_tt_s2_ff <= '0;
            c_tt_s3_ff <= '0;
        end else begin
            b_st_s1_ff <= b_st_in;
            b_st_s2_ff <= b_st_s1_ff;
            b_st_s3_ff <= b_st_s2_ff;
            b_tt_s1_ff <= b_ttl_in;
            b_tt_s2_ff <= b_tt_s1_ff;
            b_tt_s3_ff <= b_tt_s2_ff;
            c_st_s1_ff <= c_st_in;
            c_st_s2_ff <= c_st_s1_ff;
            c_st_s3_ff <= c_st_s2_ff;
            c_tt_s1_ff <= c_ttl_in;
            c_tt_s2_ff <= c_tt_s1_ff;
            c_tt_s3_ff <= c_tt_s2_ff;
        end
    end

    // a level is accepted only once the second and third stages agree
    logic [BP-1:0] nxt_b_st, nxt_b_tt;
    logic [C_PINS-1:0] nxt_c_st, nxt_c_tt;
    assign nxt_b_st = (b_st_s2_ff & ~(b_st_s2_ff ^ b_st_s3_ff))
                    | (b_st_ff & (b_st_s2_ff ^ b_st_s3_ff));
    assign nxt_b_tt = (b_tt_s2_ff & ~(b_tt_s2_ff ^ b_tt_s3_ff))
                    | (b_tt_ff & (b_tt_s2_ff ^ b_tt_s3_ff));
    assign nxt_c_st = (c_st_s2_ff & ~(c_st_s2_ff ^ c_st_s3_ff))
                    | (c_st_ff & (c_st_s2_ff ^ c_st_s3_ff));
    assign nxt_c_tt = (c_tt_s2_ff & ~(c_tt_s2_ff ^ c_tt_s3_ff))
                    | (c_tt_ff & (c_tt_s2_ff ^ c_tt_s3_ff));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            b_st_ff <= '0;
            b_tt_ff <= '0;
            c_st_ff <= '0;
            c_tt_ff <= '0;
        end else begin
            b_st_ff <= nxt_b_st;
            b_tt_ff <= nxt_b_tt;
            c_st_ff <= nxt_c_st;
            c_tt_ff <= nxt_c_tt;
        end
    end

    // ------------------------------------------------------------
    // digital pin levels and change detection
    // ------------------------------------------------------------
    // the input path stays live while a pin drives, so reads return
    // the real pin level, not the latch
    logic [7:0] b_pins;
    logic [7:0] c_pins;
    logic [7:0] nxt_b_pins;
    logic [7:0] nxt_c_pins;
    logic [BP-1:0] b_level_ff;
    logic [C_PINS-1:0] c_level_ff;
    logic b_change_ff;
    logic c_change_ff;

    assign b_pins = digital_read({b_st_ff, 4'h0}, {b_tt_ff, 4'h0},
                                 b_thresh_ff, b_analog_ff,
                                 gpio_pkg::B_IMPL_MASK);
    assign c_pins = digital_read(8'(c_st_ff), 8'(c_tt_ff), c_thresh_ff,
                                 c_analog_ff, C_IMPL_MASK);
    assign nxt_b_pins = b_pins;
    assign nxt_c_pins = c_pins;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            b_level_ff <= '0;
            c_level_ff <= '0;
            b_change_ff <= 1'b0;
            c_change_ff <= 1'b0;
        end else begin
            b_level_ff <= nxt_b_pins[BL+BP-1:BL];
            c_level_ff <= nxt_c_pins[C_PINS-1:0];
            b_change_ff <= |(nxt_b_pins[BL+BP-1:BL] ^ b_level_ff);
            c_change_ff <= |(nxt_c_pins[C_PINS-1:0] ^ c_level_ff);
        end
    end

    assign b_level = b_level_ff;
    assign c_level = c_level_ff;
    assign b_change = b_change_ff;
    assign c_change = c_change_ff;

    // ------------------------------------------------------------
    // bus address phase
    // ------------------------------------------------------------
    logic take;
    logic [AW-1:0] a_addr;
    logic a_lane0;
    logic [7:0] rd_byte;

    assign take = hsel & hready & (htrans == gpio_pkg::HTRANS_NONSEQ
                                   || htrans == 2'h3);
    assign a_addr = {haddr[AW-1:2], 2'h0};
    assign a_lane0 = lane0_hit(hsize, haddr[1:0]);
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_comb begin
        case (a_addr)
            gpio_pkg::B_PIN_DATA_OFS: rd_byte = b_pins;
            gpio_pkg::B_LATCH_OFS: rd_byte = b_latch_ff;
            gpio_pkg::B_DIR_OFS: rd_byte = b_dir_ff;
            gpio_pkg::B_ANALOG_OFS: rd_byte = b_analog_ff;
            gpio_pkg::B_PULLUP_OFS: rd_byte = b_pullup_ff;
            gpio_pkg::B_THRESH_OFS: rd_byte = b_thresh_ff;
            gpio_pkg::C_PIN_DATA_OFS: rd_byte = c_pins;
            gpio_pkg::C_LATCH_OFS: rd_byte = c_latch_ff;
            gpio_pkg::C_DIR_OFS: rd_byte = c_dir_ff;
            gpio_pkg::C_ANALOG_OFS: rd_byte = c_analog_ff;
            gpio_pkg::C_PULLUP_OFS: rd_byte = c_pullup_ff;
            gpio_pkg::C_THRESH_OFS: rd_byte = c_thresh_ff;
            gpio_pkg::OPTION_OFS: rd_byte = option_ff;
            default: rd_byte = 8'h00;
        endcase
    end

    logic [31:0] nxt_hrdata;
    assign nxt_hrdata = (take && !hwrite && haddr[31:AW] == '0) ?
                        {24'h0, rd_byte} : hrdata_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= 32'h0000_0000;
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= '0;
            lane0_ff <= 1'b0;
        end else begin
            hrdata_ff <= nxt_hrdata;
            wr_pend_ff <= take & hwrite & (haddr[31:AW] == '0);
            wr_addr_ff <= a_addr;
            lane0_ff <= a_lane0;
        end
    end

    assign hrdata = hrdata_ff;

    // ------------------------------------------------------------
    // bus data phase: register writes
    // ------------------------------------------------------------
    logic [7:0] wb;
    logic we_lane;
    assign wb = hwdata[7:0];
    assign we_lane = wr_pend_ff & lane0_ff;

    // a pin data write with the low byte untouched stores the sampled
    // levels, so analog pins driven as outputs may lose their latch
    logic [7:0] b_rmw;
    logic [7:0] c_rmw;
    assign b_rmw = lane0_ff ? wb : b_pins;
    assign c_rmw = lane0_ff ? wb : c_pins;

    logic [7:0] nxt_b_latch, nxt_b_dir, nxt_b_analog, nxt_b_pullup;
    logic [7:0] nxt_b_thresh, nxt_c_latch, nxt_c_dir, nxt_c_analog;
    logic [7:0] nxt_c_pullup, nxt_c_thresh, nxt_option;

    always_comb begin
        nxt_b_latch = b_latch_ff;
        nxt_b_dir = b_dir_ff;
        nxt_b_analog = b_analog_ff;
        nxt_b_pullup = b_pullup_ff;
        nxt_b_thresh = b_thresh_ff;
        nxt_c_latch = c_latch_ff;
        nxt_c_dir = c_dir_ff;
        nxt_c_analog = c_analog_ff;
        nxt_c_pullup = c_pullup_ff;
        nxt_c_thresh = c_thresh_ff;
        nxt_option = option_ff;
        if (wr_pend_ff) begin
            case (wr_addr_ff)
                gpio_pkg::B_PIN_DATA_OFS: nxt_b_latch = masked_write(
                    b_latch_ff, b_rmw, gpio_pkg::B_IMPL_MASK);
                gpio_pkg::C_PIN_DATA_OFS: nxt_c_latch = masked_write(
                    c_latch_ff, c_rmw, C_IMPL_MASK);
                default: nxt_option = option_ff;
            endcase
        end
        if (we_lane) begin
            case (wr_addr_ff)
                gpio_pkg::B_LATCH_OFS: nxt_b_latch = masked_write(
                    b_latch_ff, wb, gpio_pkg::B_IMPL_MASK);
                gpio_pkg::B_DIR_OFS: nxt_b_dir = masked_write(
                    b_dir_ff, wb, gpio_pkg::B_IMPL_MASK);
                gpio_pkg::B_ANALOG_OFS: nxt_b_analog = masked_write(
                    b_analog_ff, wb, gpio_pkg::B_ANALOG_MASK);
                gpio_pkg::B_PULLUP_OFS: nxt_b_pullup = masked_write(
                    b_pullup_ff, wb, gpio_pkg::B_IMPL_MASK);
                gpio_pkg::B_THRESH_OFS: nxt_b_thresh = masked_write(
                    b_thresh_ff, wb, gpio_pkg::B_IMPL_MASK);
                gpio_pkg::C_LATCH_OFS: nxt_c_latch = masked_write(
                    c_latch_ff, wb, C_IMPL_MASK);
                gpio_pkg::C_DIR_OFS: nxt_c_dir = masked_write(
                    c_dir_ff, wb, C_IMPL_MASK);
                gpio_pkg::C_ANALOG_OFS: nxt_c_analog = masked_write(
                    c_analog_ff, wb, C_ANA_MASK);
                gpio_pkg::C_PULLUP_OFS: nxt_c_pullup = masked_write(
                    c_pullup_ff, wb, C_IMPL_MASK);
                gpio_pkg::C_THRESH_OFS: nxt_c_thresh = masked_write(
                    c_thresh_ff, wb, C_IMPL_MASK);
                gpio_pkg::OPTION_OFS: nxt_option = masked_write(option_ff,
                    wb, 8'(1 << gpio_pkg::GLOBAL_PU_DIS_BIT));
                default: nxt_option = nxt_option;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            b_latch_ff <= gpio_pkg::LATCH_RST;
            b_dir_ff <= gpio_pkg::DIR_RST & gpio_pkg::B_IMPL_MASK;
            b_analog_ff <= gpio_pkg::ANALOG_RST & gpio_pkg::B_ANALOG_MASK;
            b_pullup_ff <= gpio_pkg::PULLUP_RST & gpio_pkg::B_IMPL_MASK;
            b_thresh_ff <= gpio_pkg::B_THRESH_RST;
            c_latch_ff <= gpio_pkg::LATCH_RST;
            c_dir_ff <= gpio_pkg::DIR_RST & C_IMPL_MASK;
            c_analog_ff <= gpio_pkg::ANALOG_RST & C_ANA_MASK;
            c_pullup_ff <= gpio_pkg::PULLUP_RST & C_IMPL_MASK;
            c_thresh_ff <= gpio_pkg::C_THRESH_RST & C_IMPL_MASK;
            option_ff <= gpio_pkg::OPTION_RST;
        end else begin
            b_latch_ff <= nxt_b_latch;
            b_dir_ff <= nxt_b_dir;
            b_analog_ff <= nxt_b_analog;
            b_pullup_ff <= nxt_b_pullup;
            b_thresh_ff <= nxt_b_thresh;
            c_latch_ff <= nxt_c_latch;
            c_dir_ff <= nxt_c_dir;
            c_analog_ff <= nxt_c_analog;
            c_pullup_ff <= nxt_c_pullup;
            c_thresh_ff <= nxt_c_thresh;
            option_ff <= nxt_option;
        end
    end

    // ------------------------------------------------------------
    // output selection per pin
    // ------------------------------------------------------------
    pin_select_if #(.W(BP), .NS(NS)) b_sel ();
    pin_select_if #(.W(C_PINS), .NS(NS)) c_sel ();

    assign b_sel.src_en = b_src_en;
    assign b_sel.src_drv = b_src_drv;
    assign b_sel.src_val = b_src_val;
    assign b_sel.lat = b_latch_ff[BL+BP-1:BL];
    assign b_sel.dir = b_dir_ff[BL+BP-1:BL];
    assign c_sel.src_en = c_src_en;
    assign c_sel.src_drv = c_src_drv;
    assign c_sel.src_val = c_src_val;
    assign c_sel.lat = c_latch_ff[C_PINS-1:0];
    assign c_sel.dir = c_dir_ff[C_PINS-1:0];

    pin_priority_select #(.W(BP), .NS(NS)) b_select (
        .port(b_sel.sel)
    );
    pin_priority_select #(.W(C_PINS), .NS(NS)) c_select (
        .port(c_sel.sel)
    );

    // ------------------------------------------------------------
    // pad controls
    // ------------------------------------------------------------
    // analog select never touches the driver path
    assign b_out = b_sel.pin_val;
    assign b_oe_n = ~b_sel.pin_drv;
    assign c_out = c_sel.pin_val;
    assign c_oe_n = ~c_sel.pin_drv;
    assign b_dig_in_en = ~b_analog_ff[BL+BP-1:BL];
    assign c_dig_in_en = ~c_analog_ff[C_PINS-1:0];

    logic pu_global;
    assign pu_global = ~option_ff[gpio_pkg::GLOBAL_PU_DIS_BIT];
    assign b_pullup_on = b_pullup_ff[BL+BP-1:BL] & {BP{pu_global}}
                       & ~b_sel.pin_drv;
    assign c_pullup_on = c_pullup_ff[C_PINS-1:0] & {C_PINS{pu_global}}
                       & ~c_sel.pin_drv;
endmodule

/* gpio_port_assertions.sv */
// checker of pin and bus relations at the gpio port block ports
`timescale 1ns/1ps
module gpio_port_assertions #(parameter int C_PINS = 8) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [31:0] hrdata,
    input wire logic [gpio_pkg::B_PINS-1:0] b_oe_n,
    input wire logic [gpio_pkg::B_PINS-1:0] b_out,
    input wire logic [gpio_pkg::B_PINS-1:0] b_pullup_on,
    input wire logic [gpio_pkg::B_PINS-1:0] b_dig_in_en,
    input wire logic [gpio_pkg::B_PINS-1:0] b_level,
    input wire logic b_change,
    input wire logic [gpio_pkg::B_PINS*gpio_pkg::NSRC-1:0] b_src_en,
    input wire logic [gpio_pkg::B_PINS*gpio_pkg::NSRC-1:0] b_src_drv,
    input wire logic [gpio_pkg::B_PINS*gpio_pkg::NSRC-1:0] b_src_val,
    input wire logic [C_PINS-1:0] c_oe_n,
    input wire logic [C_PINS-1:0] c_pullup_on
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // only pins 5 and 4 can be analog; eight cycles let the level settle
    sequence s_off; (b_dig_in_en[1:0] == 2'h0) [*8]; endsequence
    property p_pu_b; (~b_oe_n & b_pullup_on) == 4'h0; endproperty
    a_pu_b: assert property (p_pu_b) else $error("b pull-up on output");
    property p_pu_c; (~c_oe_n & c_pullup_on) == '0; endproperty
    a_pu_c: assert property (p_pu_c) else $error("c pull-up on output");
    property p_rst; $rose(hresetn) |-> !b_pullup_on && !c_pullup_on; endproperty
    a_rst: assert property (p_rst) else $error("pull-up on after reset");
    property p_hi; hrdata[31:8] == 24'h0; endproperty
    a_hi: assert property (p_hi) else $error("upper read bits set");
    property p_ana; s_off |-> b_level[1:0] == 2'h0; endproperty
    a_ana: assert property (p_ana) else $error("analog level not zero");
    property p_chg; b_change |-> b_level != $past(b_level); endproperty
    a_chg: assert property (p_chg) else $error("change without edge");
    property p_drv;
        b_src_en[0] && b_src_drv[0] |-> !b_oe_n[0] && b_out[0] == b_src_val[0];
    endproperty
    a_drv: assert property (p_drv) else $error("top source lost pin");
    property p_in; b_src_en[0] && !b_src_drv[0] |-> b_oe_n[0]; endproperty
    a_in: assert property (p_in) else $error("input source driven");
endmodule
bind gpio_port_block gpio_port_assertions #(.C_PINS(C_PINS)) chk (
    .hclk(hclk), .hresetn(hresetn), .hrdata(hrdata), .b_oe_n(b_oe_n),
    .b_out(b_out), .b_pullup_on(b_pullup_on), .b_dig_in_en(b_dig_in_en),
    .b_level(b_level), .b_change(b_change), .b_src_en(b_src_en),
    .b_src_drv(b_src_drv), .b_src_val(b_src_val), .c_oe_n(c_oe_n),
    .c_pullup_on(c_pullup_on));

/* pin_board_model.sv */
// board side: pins held by outside circuitry unless the block drives them
`timescale 1ns/1ps
module pin_board_model #(parameter int W = 4) (
    input wire logic [W-1:0] oe_n,
    input wire logic [W-1:0] out,
    input wire logic [W-1:0] ext,
    input wire logic [W-1:0] ttl_flip,
    output logic [W-1:0] st_in,
    output logic [W-1:0] ttl_in
);
    // outside source is weak, so a driven pin always wins
    assign st_in = (~oe_n & out) | (oe_n & ext);
    // marginal voltage: the two receivers may disagree
    assign ttl_in = st_in ^ ttl_flip;
endmodule

/* tb.sv */
// self-checking bench for the gpio port block
`timescale 1ns/1ps
module tb;
    logic hclk = 0, hresetn = 0, hwrite = 0;
    logic [1:0] htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, q;
    logic [19:0] b_en = 0, b_drv = 0, b_val = 0;
    logic [3:0] b_ext = 0, b_flip = 0;
    logic [7:0] c_ext = 8'h00;
    wire hreadyout, hresp, b_chg;
    wire [31:0] hrdata;
    wire [3:0] b_st, b_ttl, b_out, b_oe_n, b_pu, b_dig;
    wire [7:0] c_st, c_ttl, c_out, c_oe_n;
    int n_errors = 0, num_checks = 0, cyc = 0;
    always #50 hclk = ~hclk;
    gpio_port_block #(.C_PINS(8)) dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .b_st_in(b_st), .b_ttl_in(b_ttl), .b_out(b_out), .b_oe_n(b_oe_n),
        .b_pullup_on(b_pu), .b_dig_in_en(b_dig), .b_level(), .b_change(b_chg),
        .b_src_en(b_en), .b_src_drv(b_drv), .b_src_val(b_val),
        .c_st_in(c_st), .c_ttl_in(c_ttl), .c_out(c_out), .c_oe_n(c_oe_n),
        .c_pullup_on(), .c_dig_in_en(), .c_level(), .c_change(),
        .c_src_en({2{b_en}}), .c_src_drv({2{b_drv}}), .c_src_val({2{b_val}}));
    pin_board_model #(.W(4)) bm (.oe_n(b_oe_n), .out(b_out), .ext(b_ext),
        .ttl_flip(b_flip), .st_in(b_st), .ttl_in(b_ttl));
    pin_board_model #(.W(8)) cm (.oe_n(c_oe_n), .out(c_out), .ext(c_ext),
        .ttl_flip({2{b_flip}}), .st_in(c_st), .ttl_in(c_ttl));
    task conclude;
        if (n_errors == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            conclude;
        end
    end
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        num_checks++;
        if (s !== e) begin
            $display("Error %s expected %h seen %h", n, e, s);
            n_errors++;
        end
    endtask
    // one single word transfer; read data taken at the data phase edge
    task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge hclk);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input string n);
        xfer(a, 1'b0, 32'h0);
        chk(n, e, q);
    endtask
    task t_reset;
        logic [7:0] ra[9] = '{8'h08, 8'h0C, 8'h10, 8'h14, 8'h40, 8'h28,
            8'h2C, 8'h34, 8'h3C};
        logic [7:0] rv[9] = '{8'hF0, 8'h30, 8'hF0, 8'h00, 8'h80, 8'hFF,
            8'hCF, 8'hFF, 8'h00};
        xfer(8'h3C, 1'b1, 32'hFFFFFFFF);
        for (int i = 0; i < 9; i++) rd(ra[i], {24'h0, rv[i]}, "reset");
        xfer(8'h14, 1'b1, 32'hFFFFFFFF);
        rd(8'h14, 32'hF0, "b thresh");
        xfer(8'h14, 1'b1, 32'h0);
    endtask
    task t_drive;
        xfer(8'h40, 1'b1, 32'h0);
        xfer(8'h08, 1'b1, 32'h0);
        xfer(8'h00, 1'b1, 32'hA0);
        rd(8'h04, 32'hA0, "b latch");
        chk("b_out", 4'hA, b_out);
        chk("b_oe_n", 4'h0, b_oe_n);
        chk("b_pullup_on", 4'h0, b_pu);
        repeat (8) @(posedge hclk);
        rd(8'h00, 32'h80, "b pins");
    endtask
    task t_input;
        xfer(8'h08, 1'b1, 32'hF0);
        xfer(8'h0C, 1'b1, 32'h0);
        @(posedge hclk);
        chk("b_oe_n", 4'hF, b_oe_n);
        chk("b_pullup_on", 4'hF, b_pu);
        chk("b_dig_in_en", 4'hF, b_dig);
        b_ext <= 4'h5;
        b_flip <= 4'hF;
        repeat (8) @(posedge hclk);
        rd(8'h00, 32'hA0, "ttl read");
        xfer(8'h14, 1'b1, 32'hF0);
        repeat (8) @(posedge hclk);
        rd(8'h00, 32'h50, "schmitt read");
        xfer(8'h40, 1'b1, 32'h80);
        @(posedge hclk);
        chk("b_pullup_on", 4'h0, b_pu);
    endtask
    task t_src;
        xfer(8'h08, 1'b1, 32'h0);
        b_en <= 20'h3;
        b_drv <= 20'h3;
        b_val <= 20'h2;
        repeat (2) @(posedge hclk);
        chk("first source", 2'b00, {b_oe_n[0], b_out[0]});
        b_en <= 20'h2;
        repeat (2) @(posedge hclk);
        chk("second source", 3'b011, {b_oe_n[0], b_out[0], c_out[0]});
        b_en <= 20'h1;
        b_drv <= 20'h0;
        repeat (2) @(posedge hclk);
        chk("input override", 1'b1, b_oe_n[0]);
        b_en <= 20'h0;
    endtask
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset;
        t_drive;
        t_input;
        t_src;
        conclude;
    end
endmodule
